// ---- bench/sfe_line_peer.sv ----
/* Line peer: transmit and receive bit clocks and receive data.
   Assumes the bench starts the transmit clock before a frame. */
`timescale 1ns/1ps
`default_nettype none
module sfe_line_peer (
   // Control
   input wire logic tx_run_i,
   // Line pins
   output logic txc_o,
   output logic rxc_o,
   output logic rxd_o
);
   // Transmit clock, 400 ns, offset from the system clock
   initial begin
      txc_o = 1'b1;
      rxc_o = 1'b0;
      rxd_o = 1'b1;
      #7;
      forever begin
         #200 txc_o = tx_run_i ? ~txc_o : 1'b1;
      end
   end
   // One byte LSB first; clock only runs inside the byte
   task automatic send(input logic [7:0] b);
      #3;
      for (int i = 0; i < 8; i++) begin
         rxd_o = b[i];
         #200 rxc_o = 1'b1;
         #200 rxc_o = 1'b0;
      end
      rxd_o = ~b[7];
   endtask
endmodule // sfe_line_peer
`default_nettype wire

// ---- bench/tb_sdlc_fifo_irq_auto_rts.sv ----
/* Bench of the enhancement block: read-back rows, then transmit
   and receive cases. Assumes the line peer model beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb_sdlc_fifo_irq_auto_rts;
   logic clock_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, rv;
   logic tx_bit_clock, rxc, rxd, txd, rts_n, txq, rxq;
   int error_cnt = 0, n_checks = 0, n;
   // Rows of address and value, written then read back
   logic [11:0] rows [5] = '{12'h3c0, 12'h420, 12'h502, 12'ha08, 12'h704};
   always #25 clock_i = ~clock_i;
   // Transmit line bits taken at each transmit clock rise, newest at the top
   logic [47:0] line_q;
   always @(posedge tx_bit_clock) line_q <= {txd, line_q[47:1]};
   sfe_top i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_bit_clock_i(tx_bit_clock),
      .txd_o(txd), .rts_n_o(rts_n), .rx_bit_clock_i(rxc), .rxd_i(rxd),
      .tx_room_req_o(txq), .rx_char_req_o(rxq));
   sfe_line_peer i_peer (.tx_run_i(run), .txc_o(tx_bit_clock), .rxc_o(rxc), .rxd_o(rxd));
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic tick;
      @(posedge clock_i);
      #1;
   endtask
   // Waits for the request-to-send pin to be released, counting clocks
   task automatic wait_rts;
      n = 0;
      while (rts_n !== 1'b1 && n < 4000) begin
         tick;
         n++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #300000;
      error_cnt++;
      test_done;
   end
   initial begin
      repeat (5) @(posedge clock_i);
      chk("rts in reset", 8'h01, {7'h0, rts_n});
      reset_n_i <= 1'b1;
      wreg(4'hf, 8'h03);
      rreg(4'h7);
      chk("enh reset", 8'h00, rv);
      chk("tx room", 8'h01, {7'h0, txq});
      foreach (rows[i]) begin
         wreg(rows[i][11:8], rows[i][7:0]);
         rreg(rows[i][11:8]);
         chk("read back", rows[i][7:0], rv);
      end
      wreg(4'hf, 8'h00);
      wreg(4'h7, 8'hff);
      rreg(4'h3);
      chk("read back off", 8'h00, rv);
      wreg(4'hf, 8'h03);
      rreg(4'h7);
      chk("enh kept", 8'h04, rv);
      // Fill transmit FIFO; fifth byte is dropped
      for (int i = 0; i < 5; i++) begin
         wreg(4'h8, 8'(8'h31 + i));
         tick;
         chk("tx room", {7'h0, i < 3}, {7'h0, txq});
      end
      wreg(4'h7, 8'h24);
      wreg(4'h5, 8'h0a);
      wreg(4'h5, 8'h08);
      run <= 1'b1;
      tick;
      chk("rts held", 8'h00, {7'h0, rts_n});
      chk("tx level", 8'h00, {7'h0, txq});
      wait_rts;
      // Four bytes and the closing flag: 40 bits of 8 clocks
      chk("rts release", 8'h01, {7'h0, n > 300 && n < 352});
      for (int i = 0; i < 5; i++) begin
         chk("line byte", (i < 4) ? 8'(8'h31 + i) : 8'h7e, line_q[8*i+8 +: 8]);
      end
      tick;
      chk("tx empty", 8'h01, {7'h0, txq});
      rreg(4'h0);
      chk("room status", 8'h04, rv & 8'h04);
      wreg(4'h3, 8'hc1);
      wreg(4'h7, 8'h2c);
      for (int i = 0; i < 4; i++) begin
         i_peer.send(8'(8'ha0 + i));
         repeat (8) tick;
         chk("rx half", {7'h0, i == 3}, {7'h0, rxq});
      end
      rreg(4'h8);
      chk("rx data", 8'ha0, rv);
      tick;
      chk("rx below half", 8'h00, {7'h0, rxq});
      rreg(4'h0);
      chk("avail status", 8'h01, rv & 8'h01);
      wreg(4'h7, 8'h24);
      repeat (2) tick;
      chk("rx each", 8'h01, {7'h0, rxq});
      // Second frame with the opening flag sent by the block
      wreg(4'h7, 8'h25);
      wreg(4'h5, 8'h0a);
      wreg(4'h8, 8'h5a);
      wreg(4'h5, 8'h08);
      wait_rts;
      chk("rts release", 8'h01, {7'h0, n > 190 && n < 210});
      chk("idle mark", 8'hff, line_q[23:16]);
      chk("open flag", 8'h7e, line_q[31:24]);
      chk("line data", 8'h5a, line_q[39:32]);
      chk("close flag", 8'h7e, line_q[47:40]);
      test_done;
   end
endmodule // tb_sdlc_fifo_irq_auto_rts
`default_nettype wire

// ---- pkg/sfe_pkg.sv ----
/*
   Shared constants and types of the SDLC enhancement block: register
   addresses, field positions, reset values, FIFO sizes and carriers.
   Assumes an 8-bit register port with a 4-bit address.
*/
package sfe_pkg;
   // Write addresses
   localparam logic [3:0] ADDR_CMD = 4'h0;
   localparam logic [3:0] ADDR_RECV_CTL = 4'h3;
   localparam logic [3:0] ADDR_MISC = 4'h4;
   localparam logic [3:0] ADDR_TX_CTL = 4'h5;
   localparam logic [3:0] ADDR_WR7 = 4'h7;
   localparam logic [3:0] ADDR_DATA = 4'h8;
   localparam logic [3:0] ADDR_LINE_CODE = 4'ha;
   localparam logic [3:0] ADDR_EXT_SEL = 4'hf;
   // Read addresses of status
   localparam logic [3:0] ADDR_LINE_STAT = 4'h0;
   localparam logic [3:0] ADDR_SPEC_STAT = 4'h1;
   // Enhancement control fields
   localparam int ENH_AUTO_FLAG = 0;
   localparam int ENH_AUTO_RTS = 2;
   localparam int ENH_RX_LEVEL = 3;
   localparam int ENH_TX_LEVEL = 5;
   // Extended select fields
   localparam int EXT_ENH_SEL = 0;
   localparam int EXT_RDBACK = 1;
   // Transmit, receive, line coding, mode and command fields
   localparam int TXC_RTS = 1;
   localparam int TXC_TX_EN = 3;
   localparam int RCV_RX_EN = 0;
   localparam int LCC_FLAG_UNDERRUN = 2;
   localparam int MISC_MODE_LSB = 4;
   localparam int CMD_ERR_RESET = 5;
   // Status fields
   localparam int LS_RX_AVAIL = 0;
   localparam int LS_TX_ROOM = 2;
   localparam int SS_OVERRUN = 5;
   // Codes and reset values
   localparam logic [1:0] MODE_SDLC = 2'h2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] SDLC_FLAG = 8'h7e;
   // FIFO sizes
   localparam int TX_DEPTH = 4;
   localparam int RX_DEPTH = 8;
   localparam logic [3:0] RX_HALF = 4'h4;
   localparam logic [2:0] TX_FULL = 3'h4;
   // Settings handed to the transmitter
   typedef struct packed {
      logic tx_en;
      logic auto_flag;
   } sfe_txcfg_s;
endpackage

// ---- verilog/sfe_fifo.sv ----
/*
   Synchronous FIFO with valid/ready on both sides and a fill count.
   Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sfe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] count_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // Storage words
   logic [AW-1:0] wr_ptr_q; // Entry location
   logic [AW-1:0] rd_ptr_q; // Exit location
   logic [$clog2(DEPTH+1)-1:0] cnt_q; // Words held
   logic push; // Word accepted
   logic pop; // Word released

   assign in_ready_o = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign count_o = cnt_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   // Storage write, no reset needed on data
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   // Pointers and count
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // sfe_fifo
`default_nettype wire

// ---- verilog/sfe_sdlc_tx.sv ----
/*
   SDLC bit transmitter: mark idle, optional opening flag, data bytes
   LSB first, closing flag when the FIFO runs dry, end-of-frame pulse.
   Assumes synchronised transmit-clock edge strobes from the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module sfe_sdlc_tx (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Transmit clock edges and settings
   input wire logic tclk_fall_i,
   input wire logic tclk_rise_i,
   input wire sfe_pkg::sfe_txcfg_s cfg_i,
   // Byte source
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_i,
   output logic byte_pop_o,
   // Line and frame events
   output logic txd_o,
   output logic eof_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_OPEN, ST_DATA, ST_CLOSE} sfe_txst_e;
   sfe_txst_e st_q; // Frame state
   logic [7:0] sh_q; // Character being sent
   logic [2:0] cnt_q; // Bit index in character
   logic eof_pend_q; // Last closing bit is on the line

   // Character sequencing, one bit per falling transmit clock edge
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= ST_IDLE;
         sh_q <= sfe_pkg::REG_RESET;
         cnt_q <= '0;
         txd_o <= 1'b1;
         byte_pop_o <= 1'b0;
      end else begin
         byte_pop_o <= 1'b0;
         if (tclk_fall_i) begin
            unique case (st_q)
               ST_IDLE: begin
                  txd_o <= 1'b1;
                  cnt_q <= '0;
                  if (cfg_i.tx_en && byte_valid_i) begin
                     if (cfg_i.auto_flag) begin
                        sh_q <= sfe_pkg::SDLC_FLAG;
                        st_q <= ST_OPEN;
                     end else begin
                        sh_q <= byte_i;
                        byte_pop_o <= 1'b1;
                        st_q <= ST_DATA;
                     end
                  end
               end
               ST_OPEN, ST_DATA, ST_CLOSE: begin
                  txd_o <= sh_q[cnt_q];
                  cnt_q <= cnt_q + 1'b1;
                  if (cnt_q == 3'h7) begin
                     if (st_q == ST_CLOSE) begin
                        st_q <= ST_IDLE;
                     end else if (cfg_i.tx_en && byte_valid_i) begin
                        sh_q <= byte_i;
                        byte_pop_o <= 1'b1;
                        st_q <= ST_DATA;
                     end else begin
                        sh_q <= sfe_pkg::SDLC_FLAG;
                        st_q <= ST_CLOSE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // End of frame at the rising edge that finishes the closing flag
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eof_pend_q <= 1'b0;
         eof_o <= 1'b0;
      end else begin
         eof_o <= eof_pend_q && tclk_rise_i;
         if (tclk_fall_i && st_q == ST_CLOSE && cnt_q == 3'h7) begin
            eof_pend_q <= 1'b1;
         end else if (tclk_rise_i) begin
            eof_pend_q <= 1'b0;
         end
      end
   end
endmodule // sfe_sdlc_tx
`default_nettype wire

// ---- verilog/sfe_top.sv ----
/*
   Channel enhancement block: register port, enhancement control mapped
   behind register seven, write register read-back, four-byte transmit
   FIFO, eight-byte receive FIFO, FIFO request levels and automatic
   request-to-send release after the closing flag.
   Assumes the register port master is on clock_i; the transmit clock,
   receive clock and receive data pins are asynchronous and sampled.
*/
// Function
// - Enhancement register behind address seven when selected
// - Receive, mode, transmit, line coding and enhancement registers readable when enabled
// - Four-byte transmit FIFO before transmitter
// - Level clear: transmit request when entry free
// - Level set: transmit request when FIFO empty
// - Status bits for room and received characters
// - Level clear: receive request per character
// - Level set: receive request at half full
// - Enhancement bit two enables automatic release
// - SDLC, no flag underrun, bit clear: release
// - Release on transmit clock rise ending flag
// - Enhancement bit zero sends opening flag
`timescale 1ns/1ps
`default_nettype none
module sfe_top (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Transmit line
   input wire logic tx_bit_clock_i,
   output logic txd_o,
   output logic rts_n_o,
   // Receive line
   input wire logic rx_bit_clock_i,
   input wire logic rxd_i,
   // Service requests
   output logic tx_room_req_o,
   output logic rx_char_req_o
);
   // Address decode shared by write and read paths
   function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
      hit = (a == target);
   endfunction

   // Write registers
   logic [7:0] receive_control_reg_q; // Receive enables
   logic [7:0] misc_mode_reg_q; // Mode selection
   logic [7:0] transmit_control_reg_q; // Transmit enable and RTS bit
   logic [7:0] wr7_q; // Ordinary register seven
   logic [7:0] line_coding_control_reg_q; // Line coding options
   logic [7:0] extended_select_reg_q; // Extended selection
   logic [7:0] enhancement_control_reg_q; // Enhancement options
   // Status and outputs
   logic overrun_q; // Receive FIFO overflow, sticky
   logic [7:0] rdata_q; // Read data register
   logic rts_hold_q; // Keeps RTS asserted until frame ends
   logic rts_n_q; // Pin register
   logic tx_req_q; // Transmit service request
   logic rx_req_q; // Receive service request
   // Synchronisers
   logic [2:0] tclk_s_q; // Transmit clock samples
   logic [2:0] rclk_s_q; // Receive clock samples
   logic [1:0] rxd_s_q; // Receive data samples
   // Receive deserialiser
   logic [7:0] rx_sh_q; // Bits gathered
   logic [2:0] rx_cnt_q; // Bits counted
   logic rx_push_q; // Character ready for FIFO
   // Decoded strobes and FIFO wires
   logic enh_sel; // Address seven means enhancement register
   logic tclk_rise; // Transmit clock rising edge
   logic tclk_fall; // Transmit clock falling edge
   logic rclk_rise; // Receive clock rising edge
   logic tx_in_ready; // Transmit FIFO room
   logic tx_out_valid; // Transmit FIFO holds a byte
   logic tx_pop; // Transmitter takes a byte
   logic [7:0] tx_head; // Next byte to send
   logic [2:0] tx_count; // Transmit fill level
   logic rx_in_ready; // Receive FIFO room
   logic rx_out_valid; // Receive FIFO holds a byte
   logic [7:0] rx_head; // Oldest received byte
   logic [3:0] rx_count; // Receive fill level
   logic eof; // Closing flag finished
   logic sdlc_mode; // Mode field selects SDLC
   logic auto_rts_ok; // Conditions for automatic release
   sfe_pkg::sfe_txcfg_s txcfg; // Transmitter settings

   assign enh_sel = extended_select_reg_q[sfe_pkg::EXT_ENH_SEL];
   assign tclk_rise = tclk_s_q[1] && !tclk_s_q[2];
   assign tclk_fall = !tclk_s_q[1] && tclk_s_q[2];
   assign rclk_rise = rclk_s_q[1] && !rclk_s_q[2];
   assign sdlc_mode = misc_mode_reg_q[sfe_pkg::MISC_MODE_LSB+1 -: 2] == sfe_pkg::MODE_SDLC;
   assign auto_rts_ok = enhancement_control_reg_q[sfe_pkg::ENH_AUTO_RTS]
      && sdlc_mode && !line_coding_control_reg_q[sfe_pkg::LCC_FLAG_UNDERRUN]
      && !transmit_control_reg_q[sfe_pkg::TXC_RTS];
   assign txcfg = '{tx_en: transmit_control_reg_q[sfe_pkg::TXC_TX_EN],
      auto_flag: enhancement_control_reg_q[sfe_pkg::ENH_AUTO_FLAG]};
   assign rdata_o = rdata_q;
   assign rts_n_o = rts_n_q;
   assign tx_room_req_o = tx_req_q;
   assign rx_char_req_o = rx_req_q;

   // Control register writes; every bit clears on reset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         receive_control_reg_q <= sfe_pkg::REG_RESET;
         misc_mode_reg_q <= sfe_pkg::REG_RESET;
         transmit_control_reg_q <= sfe_pkg::REG_RESET;
         wr7_q <= sfe_pkg::REG_RESET;
         line_coding_control_reg_q <= sfe_pkg::REG_RESET;
         extended_select_reg_q <= sfe_pkg::REG_RESET;
         enhancement_control_reg_q <= sfe_pkg::REG_RESET;
      end else if (wr_i) begin
         if (hit(addr_i, sfe_pkg::ADDR_RECV_CTL)) begin
            receive_control_reg_q <= wdata_i;
         end
         if (hit(addr_i, sfe_pkg::ADDR_MISC)) begin
            misc_mode_reg_q <= wdata_i;
         end
         if (hit(addr_i, sfe_pkg::ADDR_TX_CTL)) begin
            transmit_control_reg_q <= wdata_i;
         end
         // Address seven steered by the select bit
         if (hit(addr_i, sfe_pkg::ADDR_WR7) && enh_sel) begin
            enhancement_control_reg_q <= wdata_i;
         end
         if (hit(addr_i, sfe_pkg::ADDR_WR7) && !enh_sel) begin
            wr7_q <= wdata_i;
         end
         if (hit(addr_i, sfe_pkg::ADDR_LINE_CODE)) begin
            line_coding_control_reg_q <= wdata_i;
         end
         if (hit(addr_i, sfe_pkg::ADDR_EXT_SEL)) begin
            extended_select_reg_q <= wdata_i;
         end
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= sfe_pkg::REG_RESET;
      end else begin
         rdata_q <= sfe_pkg::REG_RESET;
         if (rd_i) begin
            unique case (addr_i)
               sfe_pkg::ADDR_LINE_STAT: begin
                  rdata_q[sfe_pkg::LS_RX_AVAIL] <= rx_out_valid;
                  rdata_q[sfe_pkg::LS_TX_ROOM] <= tx_in_ready;
               end
               sfe_pkg::ADDR_SPEC_STAT: begin
                  rdata_q[sfe_pkg::SS_OVERRUN] <= overrun_q;
               end
               sfe_pkg::ADDR_DATA: begin
                  rdata_q <= rx_head;
               end
               default: begin
                  // Read-back of written controls when enabled
                  if (extended_select_reg_q[sfe_pkg::EXT_RDBACK]) begin
                     if (hit(addr_i, sfe_pkg::ADDR_RECV_CTL)) begin
                        rdata_q <= receive_control_reg_q;
                     end else if (hit(addr_i, sfe_pkg::ADDR_MISC)) begin
                        rdata_q <= misc_mode_reg_q;
                     end else if (hit(addr_i, sfe_pkg::ADDR_TX_CTL)) begin
                        rdata_q <= transmit_control_reg_q;
                     end else if (hit(addr_i, sfe_pkg::ADDR_LINE_CODE)) begin
                        rdata_q <= line_coding_control_reg_q;
                     end else if (hit(addr_i, sfe_pkg::ADDR_WR7) && enh_sel) begin
                        rdata_q <= enhancement_control_reg_q;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Transmit FIFO between register port and transmitter
   sfe_fifo #(
      .WIDTH(8),
      .DEPTH(sfe_pkg::TX_DEPTH)
   ) u_tx_fifo (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(wr_i && hit(addr_i, sfe_pkg::ADDR_DATA)),
      .in_ready_o(tx_in_ready),
      .in_data_i(wdata_i),
      .out_valid_o(tx_out_valid),
      .out_ready_i(tx_pop),
      .out_data_o(tx_head),
      .count_o(tx_count)
   );

   // Receive FIFO between deserialiser and register port
   sfe_fifo #(
      .WIDTH(8),
      .DEPTH(sfe_pkg::RX_DEPTH)
   ) u_rx_fifo (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(rx_push_q),
      .in_ready_o(rx_in_ready),
      .in_data_i(rx_sh_q),
      .out_valid_o(rx_out_valid),
      .out_ready_i(rd_i && hit(addr_i, sfe_pkg::ADDR_DATA)),
      .out_data_o(rx_head),
      .count_o(rx_count)
   );

   // Serial transmitter
   sfe_sdlc_tx u_tx (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .tclk_fall_i(tclk_fall),
      .tclk_rise_i(tclk_rise),
      .cfg_i(txcfg),
      .byte_valid_i(tx_out_valid),
      .byte_i(tx_head),
      .byte_pop_o(tx_pop),
      .txd_o(txd_o),
      .eof_o(eof)
   );

   // Pin synchronisers; edges only look at the second stage onward
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tclk_s_q <= '1; // Pin idles high, so no false edge at release
         rclk_s_q <= '0;
         rxd_s_q <= '0;
      end else begin
         tclk_s_q <= {tclk_s_q[1:0], tx_bit_clock_i};
         rclk_s_q <= {rclk_s_q[1:0], rx_bit_clock_i};
         rxd_s_q <= {rxd_s_q[0], rxd_i};
      end
   end

   // Receive deserialiser, LSB first on rising receive clock
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_sh_q <= sfe_pkg::REG_RESET;
         rx_cnt_q <= '0;
         rx_push_q <= 1'b0;
      end else begin
         rx_push_q <= 1'b0;
         if (!receive_control_reg_q[sfe_pkg::RCV_RX_EN]) begin
            rx_cnt_q <= '0;
         end else if (rclk_rise) begin
            rx_sh_q <= {rxd_s_q[1], rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 1'b1;
            rx_push_q <= (rx_cnt_q == 3'h7);
         end
      end
   end

   // Overrun flag: a full FIFO drops the byte; set wins over reset
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         overrun_q <= 1'b0;
      end else if (rx_push_q && !rx_in_ready) begin
         overrun_q <= 1'b1;
      end else if (wr_i && hit(addr_i, sfe_pkg::ADDR_CMD) && wdata_i[sfe_pkg::CMD_ERR_RESET]) begin
         overrun_q <= 1'b0;
      end
   end

   // FIFO service request levels
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tx_req_q <= 1'b0;
         rx_req_q <= 1'b0;
      end else begin
         if (enhancement_control_reg_q[sfe_pkg::ENH_TX_LEVEL]) begin
            tx_req_q <= !tx_out_valid;
         end else begin
            tx_req_q <= tx_in_ready;
         end
         if (enhancement_control_reg_q[sfe_pkg::ENH_RX_LEVEL]) begin
            rx_req_q <= rx_count >= sfe_pkg::RX_HALF;
         end else begin
            rx_req_q <= rx_out_valid;
         end
      end
   end

   // Request-to-send: the bit drives the pin; with automatic release
   // armed the pin stays asserted until the closing flag has ended
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rts_hold_q <= 1'b0;
         rts_n_q <= 1'b1;
      end else begin
         if (!enhancement_control_reg_q[sfe_pkg::ENH_AUTO_RTS]) begin
            rts_hold_q <= 1'b0;
         end else if (transmit_control_reg_q[sfe_pkg::TXC_RTS]) begin
            rts_hold_q <= 1'b1;
         end else if (eof && auto_rts_ok) begin
            rts_hold_q <= 1'b0;
         end
         rts_n_q <= !(transmit_control_reg_q[sfe_pkg::TXC_RTS] || rts_hold_q);
      end
   end

   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_frame_end;
      eof && auto_rts_ok;
   endsequence

   sequence s_enh_write;
      wr_i && hit(addr_i, sfe_pkg::ADDR_WR7) && enh_sel;
   endsequence

   chk_enh_map: assert property (s_enh_write |=> enhancement_control_reg_q == $past(wdata_i))
      else $error("enhancement write not taken");
   chk_wr7_keep: assert property (wr_i && hit(addr_i, sfe_pkg::ADDR_WR7) && !enh_sel
      |=> $stable(enhancement_control_reg_q))
      else $error("plain register seven write reached enhancement register");
   chk_readback_rx: assert property (rd_i && hit(addr_i, sfe_pkg::ADDR_RECV_CTL)
      && extended_select_reg_q[sfe_pkg::EXT_RDBACK] |=> rdata_o == $past(receive_control_reg_q))
      else $error("read-back mismatch");
   chk_tx_depth: assert property (tx_count == sfe_pkg::TX_FULL |-> !tx_in_ready)
      else $error("transmit FIFO depth wrong");
   chk_tx_entry: assert property (reset_n_i
      && !enhancement_control_reg_q[sfe_pkg::ENH_TX_LEVEL] && tx_count < sfe_pkg::TX_FULL
      ##1 !enhancement_control_reg_q[sfe_pkg::ENH_TX_LEVEL] |-> tx_room_req_o)
      else $error("transmit request missing with room");
   chk_tx_level: assert property (enhancement_control_reg_q[sfe_pkg::ENH_TX_LEVEL]
      && tx_count != '0 |=> !tx_room_req_o)
      else $error("transmit request before FIFO empty");
   chk_status_bits: assert property (rd_i && hit(addr_i, sfe_pkg::ADDR_LINE_STAT)
      |=> rdata_o[sfe_pkg::LS_TX_ROOM] == $past(tx_in_ready)
      && rdata_o[sfe_pkg::LS_RX_AVAIL] == $past(rx_out_valid))
      else $error("status bits wrong");
   chk_rx_each: assert property (!enhancement_control_reg_q[sfe_pkg::ENH_RX_LEVEL]
      && rx_out_valid |=> rx_char_req_o || $changed(enhancement_control_reg_q))
      else $error("receive request missing");
   chk_rx_half: assert property (enhancement_control_reg_q[sfe_pkg::ENH_RX_LEVEL]
      && rx_count < sfe_pkg::RX_HALF |=> !rx_char_req_o)
      else $error("receive request below half full");
   chk_rts_release: assert property (s_frame_end ##1 !transmit_control_reg_q[sfe_pkg::TXC_RTS]
      |=> rts_n_o)
      else $error("request-to-send not released after closing flag");
   chk_rts_no_auto: assert property (!enhancement_control_reg_q[sfe_pkg::ENH_AUTO_RTS]
      ##1 !transmit_control_reg_q[sfe_pkg::TXC_RTS] |=> rts_n_o)
      else $error("request-to-send held without automatic release");
   chk_eof_edge: assert property (eof |-> $past(tclk_rise))
      else $error("frame end not on transmit clock rise");
endmodule // sfe_top
`default_nettype wire
